// >>> tsr_pkg.sv
// Shared constants, register map and carrier types of the restart block.
// Assumes a 50 MHz system clock and one aligned 32-bit word per register.
`default_nettype none

package tsr_pkg;

   localparam int unsigned CLK_PERIOD_NS   = 20;
   localparam int unsigned RESET_PULSE_NS  = 1000;
   localparam int unsigned RESET_PULSE_CYC =
      (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Register indices; byte address is four times the index
   localparam logic [15:0] SYSOPT1_IDX  = 16'h1802;
   localparam logic [15:0] SYSTST_IDX   = 16'h180F;
   localparam logic [15:0] IRQ_STAT_IDX = 16'h1810;
   localparam logic [15:0] IRQ_MASK_IDX = 16'h1811;

   localparam int unsigned RESTART_EN_BIT = 3;
   localparam int unsigned THRESH_SEL_BIT = 2;
   localparam int unsigned FLAG_BIT       = 0;

   localparam logic RESTART_EN_RST = 1'b0;
   localparam logic THRESH_SEL_RST = 1'b0;
   localparam logic FLAG_RST       = 1'b1;

   localparam int unsigned IRQ_W           = 4;
   localparam int unsigned IRQ_RESTART_BIT = 0;
   localparam int unsigned IRQ_ARMED_BIT   = 1;
   localparam int unsigned IRQ_RECOVER_BIT = 2;
   localparam int unsigned IRQ_BLOCKED_BIT = 3;
   localparam logic [IRQ_W-1:0] IRQ_STAT_RST = 4'h0;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

   localparam logic [15:0] RESET_VECTOR_ADDR = 16'hDFFE;

   typedef struct packed {
      logic rearm;
      logic recov;
   } tsr_cmp_type;

   typedef struct packed {
      tsr_cmp_type high;
      tsr_cmp_type low;
   } tsr_cmp_pair_type;

   typedef struct packed {
      logic wake;
      logic reset;
   } tsr_pwu_type;

   function automatic logic [15:0] tsr_byte_addr(input logic [15:0] idx);
      return {idx[13:0], 2'b00};
   endfunction : tsr_byte_addr

endpackage : tsr_pkg

`default_nettype wire

// >>> tsr_sync.sv
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes each bit is an independent level; no bus coherence is given.
`default_nettype none

module tsr_sync
   import tsr_pkg::*;
#(
   parameter int unsigned W = 4
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } tsr_sync_state_type;

   tsr_sync_state_type s_q;
   tsr_sync_state_type s_d;

   always_comb begin
      s_d    = s_q;
      s_d.s1 = d;
      s_d.s2 = s_q.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign q = s_q.s2;

endmodule : tsr_sync

`default_nettype wire

// >>> tsr_band_track.sv
// Hysteresis tracker of the outside-rearm flag.
// Assumes rearm and recov are already synchronised levels.
`default_nettype none

module tsr_band_track
   import tsr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire tsr_cmp_type cmp,
   output logic             flag,
   output logic             rise,
   output logic             fall
);

   typedef struct packed {
      logic flag;
      logic rise;
      logic fall;
   } tsr_track_state_type;

   tsr_track_state_type s_q;
   tsr_track_state_type s_d;

   always_comb begin
      s_d      = s_q;
      s_d.rise = 1'b0;
      s_d.fall = 1'b0;
      if (!s_q.flag && cmp.rearm) begin // [R15]
         s_d.flag = 1'b1;
         s_d.rise = 1'b1;
      end else if (s_q.flag && cmp.recov && !cmp.rearm) begin // [R15]
         s_d.flag = 1'b0;
         s_d.fall = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{flag: FLAG_RST, rise: 1'b0, fall: 1'b0}; // [R12]
      end else begin
         s_q <= s_d;
      end
   end

   assign flag = s_q.flag;
   assign rise = s_q.rise;
   assign fall = s_q.fall;

endmodule : tsr_band_track

`default_nettype wire

// >>> tsr_top.sv
// Temperature restart unit: APB registers, rearm tracking, core restart
// and gating of the periodic wake-up timer's interrupt and reset.
// Assumes comparator levels are asynchronous and wake-up timer events are
// one-cycle pulses on SYS_CLK.
//
// How it works
// [R01] Wake-up interrupt and periodic reset are blocked during shutdown.
// [R02] Software arms low shutdown: enable set, threshold select cleared.
// [R03] Software arms high shutdown: enable set, threshold select set.
// [R04] At the programmed limit the core enters its deepest stop mode.
// [R05] Return to the recovery band resets the core to its fixed vector.
// [R06] Restart enable is bit 3 of option register 1; powers the unit.
// [R07] Reset clears the restart enable bit.
// [R08] Threshold select picks high or low recovery detection.
// [R09] Reset clears the threshold select bit.
// [R10] No restart unless the flag first went outside the rearm band.
// [R11] Outside-rearm flag reads at bit 0 of the system test register.
// [R12] Reset forces the outside-rearm flag to one.
// [R13] Flag one: restart when enabled and temperature returns to band.
// [R14] Flag zero: writes setting restart enable have no effect.
// [R15] Flag rises at the rearm threshold, falls at the recovery one.
// [R16] Gating only while enabled and flag one; counters keep running.
// [R17] Comparator levels pass two flops before updating the flag.
//
// Design decisions made here: the register offsets and register access over APB.
`default_nettype none

module tsr_top
   import tsr_pkg::*;
#(
   parameter int unsigned RESET_CYC = RESET_PULSE_CYC
) (
   input  wire logic             SYS_CLK,
   input  wire logic             RST_N,
   input  wire logic             PSEL,
   input  wire logic             PENABLE,
   input  wire logic             PWRITE,
   input  wire logic [15:0]      PADDR,
   input  wire logic [31:0]      PWDATA,
   input  wire logic [3:0]       PSTRB,
   output logic                  PREADY,
   output logic      [31:0]      PRDATA,
   output logic                  PSLVERR,
   input  wire tsr_cmp_pair_type TEMP_CMP,
   input  wire tsr_pwu_type      PWU_EVENT,
   output tsr_pwu_type           PWU_GATED,
   output logic                  CORE_RESET,
   output logic      [15:0]      CORE_VECTOR,
   output logic                  UNIT_POWER,
   output logic                  OUTSIDE_REARM,
   output logic                  IRQ
);

   localparam int unsigned CNT_W = $clog2(RESET_CYC + 1);
   localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(RESET_CYC);

   typedef struct packed {
      logic              restart_en;
      logic              thresh_sel;
      logic [IRQ_W-1:0]  irq_stat;
      logic [IRQ_W-1:0]  irq_mask;
      logic              pready;
      logic              pslverr;
      logic [31:0]       prdata;
      logic [CNT_W-1:0]  rst_cnt;
      logic              core_reset;
      tsr_pwu_type       pwu_out;
      logic              irq;
      logic [15:0]       vector;
   } tsr_top_state_type;

   tsr_top_state_type s_q;
   tsr_top_state_type s_d;

   tsr_cmp_pair_type  cmp_s;
   tsr_cmp_type       cmp_sel;
   logic              flag;
   logic              flag_rise;
   logic              flag_fall;

   logic              setup;
   logic              access;
   logic              wr;
   logic              hit_opt;
   logic              hit_tst;
   logic              hit_stat;
   logic              hit_mask;
   logic              gate;
   logic              restart_ev;
   logic [IRQ_W-1:0]  events;

   tsr_sync #(
      .W (4)
   ) u_sync (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .d     (TEMP_CMP), // [R17]
      .q     (cmp_s)
   );

   // Chosen comparator pair follows the threshold select bit
   assign cmp_sel = s_q.thresh_sel ? cmp_s.high : cmp_s.low; // [R08]

   tsr_band_track u_track (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .cmp   (cmp_sel),
      .flag  (flag),
      .rise  (flag_rise),
      .fall  (flag_fall)
   );

   // Address decode on the full byte address
   always_comb begin
      hit_opt  = 1'b0;
      hit_tst  = 1'b0;
      hit_stat = 1'b0;
      hit_mask = 1'b0;
      if (PADDR == tsr_byte_addr(SYSOPT1_IDX)) begin
         hit_opt = 1'b1;
      end else if (PADDR == tsr_byte_addr(SYSTST_IDX)) begin
         hit_tst = 1'b1;
      end else if (PADDR == tsr_byte_addr(IRQ_STAT_IDX)) begin
         hit_stat = 1'b1;
      end else if (PADDR == tsr_byte_addr(IRQ_MASK_IDX)) begin
         hit_mask = 1'b1;
      end
   end

   assign setup  = PSEL && !PENABLE;
   assign access = PSEL && PENABLE && s_q.pready;
   assign wr     = access && PWRITE && !s_q.pslverr && PSTRB[0];

   // Shutdown in effect: unit enabled and still outside the recovery band
   assign gate       = s_q.restart_en && flag; // [R16]
   assign restart_ev = flag_fall && s_q.restart_en; // [R10] [R13]

   always_comb begin
      events                  = '0;
      events[IRQ_RESTART_BIT] = restart_ev;
      events[IRQ_ARMED_BIT]   = flag_rise;
      events[IRQ_RECOVER_BIT] = flag_fall;
      events[IRQ_BLOCKED_BIT] = gate && (PWU_EVENT.wake || PWU_EVENT.reset);
   end

   always_comb begin
      s_d = s_q;

      // APB: one wait-free access phase, data captured in setup
      s_d.pready  = setup;
      s_d.pslverr = setup && !(hit_opt || hit_tst || hit_stat || hit_mask);
      s_d.prdata  = '0;
      if (setup) begin
         if (hit_opt) begin
            s_d.prdata[RESTART_EN_BIT] = s_q.restart_en; // [R06]
            s_d.prdata[THRESH_SEL_BIT] = s_q.thresh_sel;
         end else if (hit_tst) begin
            s_d.prdata[FLAG_BIT] = flag; // [R11]
         end else if (hit_stat) begin
            s_d.prdata[IRQ_W-1:0] = s_q.irq_stat;
         end else if (hit_mask) begin
            s_d.prdata[IRQ_W-1:0] = s_q.irq_mask;
         end
      end

      if (wr && hit_opt) begin
         s_d.thresh_sel = PWDATA[THRESH_SEL_BIT]; // [R08]
         if (!PWDATA[RESTART_EN_BIT]) begin
            s_d.restart_en = 1'b0; // [R06]
         end else if (flag) begin
            s_d.restart_en = 1'b1; // [R14]
         end
      end

      if (wr && hit_mask) begin
         s_d.irq_mask = PWDATA[IRQ_W-1:0];
      end

      // Write-one-to-clear; a new event in the same cycle wins
      if (wr && hit_stat) begin
         s_d.irq_stat = s_q.irq_stat & ~PWDATA[IRQ_W-1:0];
      end
      s_d.irq_stat = s_d.irq_stat | events;
      s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);

      // Core restart pulse; the core then fetches from the fixed vector
      if (restart_ev) begin
         s_d.rst_cnt = CNT_LOAD; // [R05]
      end else if (s_q.rst_cnt != '0) begin
         s_d.rst_cnt = s_q.rst_cnt - CNT_W'(1);
      end
      s_d.core_reset = (s_d.rst_cnt != '0); // [R05]
      s_d.vector     = RESET_VECTOR_ADDR; // [R05]

      // Timer events pass only while no shutdown is in effect
      s_d.pwu_out.wake  = PWU_EVENT.wake && !gate; // [R01] [R16]
      s_d.pwu_out.reset = PWU_EVENT.reset && !gate; // [R01] [R16]
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         s_q            <= '0;
         s_q.restart_en <= RESTART_EN_RST; // [R07]
         s_q.thresh_sel <= THRESH_SEL_RST; // [R09]
         s_q.irq_stat   <= IRQ_STAT_RST;
         s_q.irq_mask   <= IRQ_MASK_RST;
         s_q.vector     <= RESET_VECTOR_ADDR;
      end else begin
         s_q <= s_d;
      end
   end

   assign PREADY        = s_q.pready;
   assign PRDATA        = s_q.prdata;
   assign PSLVERR       = s_q.pslverr;
   assign PWU_GATED     = s_q.pwu_out;
   assign CORE_RESET    = s_q.core_reset;
   assign CORE_VECTOR   = s_q.vector;
   assign UNIT_POWER    = s_q.restart_en; // [R06]
   assign OUTSIDE_REARM = flag;
   assign IRQ           = s_q.irq;

endmodule : tsr_top

`default_nettype wire

// >>> tsr_props.sv
// Port checker of the restart unit, bound into tsr_top.
// Assumes comparator levels are held for several cycles at a time.
`default_nettype none
module tsr_props
   import tsr_pkg::*;
#(
   parameter int unsigned RESET_CYC = 2
) (
   input wire logic             SYS_CLK,
   input wire logic             RST_N,
   input wire tsr_cmp_pair_type TEMP_CMP,
   input wire tsr_pwu_type      PWU_EVENT,
   input wire tsr_pwu_type      PWU_GATED,
   input wire logic             CORE_RESET,
   input wire logic      [15:0] CORE_VECTOR,
   input wire logic             UNIT_POWER,
   input wire logic             OUTSIDE_REARM
);
   int unsigned hi_q;
   int unsigned hi_d;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   // Length of the running core reset pulse
   always_comb hi_d = CORE_RESET ? hi_q + 1 : 0;
   always_ff @(posedge SYS_CLK or negedge RST_N)
      if (!RST_N) hi_q <= 0;
      else hi_q <= hi_d;
   a_block_gate: assert property (
      UNIT_POWER && OUTSIDE_REARM |=> PWU_GATED == 2'b00)
      else $error("event passed while blocked");
   a_gate_pass: assert property (
      !(UNIT_POWER && OUTSIDE_REARM) |=> PWU_GATED == $past(PWU_EVENT))
      else $error("event lost while not blocked");
   a_flag_rise: assert property (
      $rose(OUTSIDE_REARM) |->
         $past(TEMP_CMP.high.rearm, 3) || $past(TEMP_CMP.low.rearm, 3))
      else $error("flag rose without rearm");
   a_flag_fall: assert property (
      $fell(OUTSIDE_REARM) |->
         $past(TEMP_CMP.high.recov, 3) || $past(TEMP_CMP.low.recov, 3))
      else $error("flag fell without recovery");
   a_restart_go: assert property (
      $fell(OUTSIDE_REARM) && UNIT_POWER |=> CORE_RESET)
      else $error("no restart on recovery");
   a_restart_cause: assert property (
      $rose(CORE_RESET) |->
         $past(OUTSIDE_REARM, 2) && !$past(OUTSIDE_REARM) && $past(UNIT_POWER))
      else $error("restart without armed unit");
   a_pulse_len: assert property (
      $fell(CORE_RESET) |-> hi_q == RESET_CYC)
      else $error("core reset pulse length wrong");
   a_en_locked: assert property (
      !OUTSIDE_REARM && !UNIT_POWER |=> !UNIT_POWER)
      else $error("enable set while flag low");
   a_vector_fix: assert property (
      CORE_VECTOR == 16'hDFFE)
      else $error("reset vector wrong");
   c_restart: cover property ($rose(CORE_RESET));
   c_blocked: cover property (UNIT_POWER && OUTSIDE_REARM && |PWU_EVENT);
   c_rearm: cover property ($rose(OUTSIDE_REARM));
endmodule : tsr_props

bind tsr_top tsr_props #(.RESET_CYC(RESET_CYC)) u_props (
   .SYS_CLK(SYS_CLK), .RST_N(RST_N), .TEMP_CMP(TEMP_CMP),
   .PWU_EVENT(PWU_EVENT), .PWU_GATED(PWU_GATED), .CORE_RESET(CORE_RESET),
   .CORE_VECTOR(CORE_VECTOR), .UNIT_POWER(UNIT_POWER),
   .OUTSIDE_REARM(OUTSIDE_REARM));
`default_nettype wire

// >>> tsr_far_model.sv
// Model of the core and the wake-up timer beside the restart unit.
// Assumes events are one-cycle pulses on the system clock.
`default_nettype none
module tsr_far_model
   import tsr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ev_en,
   input  wire logic        stop_req,
   input  wire logic        core_reset,
   output tsr_pwu_type      ev_o,
   output logic             stopped,
   output int               restarts
);
   logic rst_seen;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ev_o <= '0;
         stopped <= 1'b0;
         restarts <= 0;
         rst_seen <= 1'b0;
      end else begin
         // Timer pulses run only in the windows the bench opens
         ev_o <= ev_en ? tsr_pwu_type'(2'($urandom)) : '0;
         rst_seen <= core_reset;
         if (stop_req)
            stopped <= 1'b1;
         if (core_reset && !rst_seen) begin
            stopped <= 1'b0;
            restarts <= restarts + 1;
         end
      end
   end
endmodule : tsr_far_model
`default_nettype wire

// >>> thermal_shutdown_restart_tb.sv
// Self-checking bench of the restart unit against an integer model.
// Assumes zero-wait APB and RESET_CYC of 2.
`default_nettype none
`define CHK(nm, e, g) \
   begin num_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
module thermal_shutdown_restart_tb
   import tsr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] A_OPT = 16'h6008, A_TST = 16'h603C;
   localparam logic [15:0] A_STAT = 16'h6040, A_MASK = 16'h6044;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic ev_en = 0, stop_req = 0, pready, pslverr, core_reset;
   logic unit_power, outside_rearm, irq, stopped, er;
   logic [15:0] paddr = '0, core_vector;
   logic [31:0] pwdata = '0, prdata, d;
   logic [1:0] exp_g = '0;
   tsr_cmp_pair_type temp_cmp = '0;
   tsr_pwu_type pwu_event, pwu_gated;
   int n_errors = 0, num_checks = 0, restarts, m_rst = 0;
   int m_en = 0, m_sel = 0, m_flag = 1, m_stat = 0, m_mask = 0;
   tsr_top #(.RESET_CYC(2)) dut (.SYS_CLK(clk), .RST_N(rst_n),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PSTRB(4'hF), .PREADY(pready), .PRDATA(prdata),
      .PSLVERR(pslverr), .TEMP_CMP(temp_cmp), .PWU_EVENT(pwu_event),
      .PWU_GATED(pwu_gated), .CORE_RESET(core_reset),
      .CORE_VECTOR(core_vector), .UNIT_POWER(unit_power),
      .OUTSIDE_REARM(outside_rearm), .IRQ(irq));
   tsr_far_model far (.clk(clk), .rst_n(rst_n), .ev_en(ev_en),
      .stop_req(stop_req), .core_reset(core_reset), .ev_o(pwu_event),
      .stopped(stopped), .restarts(restarts));
   always #10 clk = ~clk;
   // Gated events against the model, every cycle
   always @(posedge clk) begin
      if (rst_n)
         `CHK("gated", exp_g, pwu_gated)
      exp_g = pwu_event & ~{2{m_en != 0 && m_flag != 0}};
      if (m_en != 0 && m_flag != 0 && |pwu_event)
         m_stat |= 8;
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   task automatic apb(input logic w, input logic [15:0] a,
                      input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // Look at the settled answer ahead of the edge that completes it
      do begin
         @(negedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      d = prdata;
      er = pslverr;
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      if (n >= 20) begin
         n_errors++;
         finish_test();
      end
   endtask : apb
   task automatic wr(input logic [15:0] a, input logic [31:0] wd);
      apb(1'b1, a, wd);
      if (a == A_OPT) begin
         m_sel = wd[2];
         if (m_flag != 0 || !wd[3])
            m_en = wd[3];
      end
      if (a == A_STAT)
         m_stat &= ~int'(wd[3:0]);
      if (a == A_MASK)
         m_mask = wd[3:0];
   endtask : wr
   task automatic rd(input string nm, input logic [15:0] a,
                     input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, d)
      `CHK("slverr", 1'b0, er)
   endtask : rd
   task automatic temp(input logic [3:0] v);
      logic [1:0] p;
      temp_cmp <= v;
      repeat (10) @(posedge clk);
      p = m_sel != 0 ? v[3:2] : v[1:0];
      if (p[1]) begin
         if (m_flag == 0)
            m_stat |= 2;
         m_flag = 1;
      end else if (p[0] && m_flag != 0) begin
         m_flag = 0;
         m_stat |= 4;
         if (m_en != 0) begin
            m_stat |= 1;
            m_rst++;
         end
      end
   endtask : temp
   task automatic gate;
      ev_en <= 1'b1;
      repeat (20) @(posedge clk);
      ev_en <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : gate
   initial begin
      void'($urandom(32'h9EF9B27D));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd("opt_rst", A_OPT, 32'h0);
      rd("flag_rst", A_TST, 32'h1);
      rd("mask_rst", A_MASK, 32'h0);
      apb(1'b0, 16'h7000, 32'h0);
      `CHK("unmapped", 1'b1, er)
      temp(4'h1);
      rd("flag_fell", A_TST, 32'h0);
      `CHK("irq_masked", 1'b0, irq)
      `CHK("no_restart", m_rst, restarts)
      $display("reset test done");
      wr(A_MASK, 32'hF);
      for (int s = 1; s >= 0; s--) begin
         wr(A_OPT, 32'h8 | (s << 2));
         rd("opt_lock", A_OPT, 32'(m_en * 8 + m_sel * 4));
         temp(s != 0 ? 4'h8 : 4'h2);
         rd("flag_rose", A_TST, 32'h1);
         wr(A_OPT, 32'h8 | (s << 2));
         rd("opt_arm", A_OPT, 32'(m_en * 8 + m_sel * 4));
         stop_req <= 1'b1;
         @(posedge clk);
         stop_req <= 1'b0;
         gate();
         rd("stat_blk", A_STAT, 32'(m_stat));
         `CHK("irq_on", (m_stat & m_mask) != 0, irq)
         temp(s != 0 ? 4'h4 : 4'h1);
         `CHK("restarts", m_rst, restarts)
         `CHK("stopped", 1'b0, stopped)
         rd("flag_low", A_TST, 32'h0);
         gate();
         wr(A_STAT, 32'hF);
         rd("stat_clr", A_STAT, 32'(m_stat));
         `CHK("irq_off", 1'b0, irq)
         $display("select %0d test done", s);
      end
      finish_test();
   end
endmodule : thermal_shutdown_restart_tb
`default_nettype wire
